// file: bench/dmabs_partner.sv
`timescale 1ns/10ps
`default_nettype none
// processor and requesting peripherals around the controller
module dmabs_partner (
  input wire logic clk_in, // clock
  input wire logic reset_in, // async reset
  input wire logic [3:0] raise_in, // start a channel request
  input wire logic [3:0] grant_wait_in, // cycles before release
  input wire logic stop_early_in, // end service from outside
  input wire logic hold_request_in, // from controller
  input wire logic [3:0] ack_in, // channel acknowledges
  input wire logic ack_high_in, // acknowledge sense
  input wire logic eop_oe_in, // controller pulls end line
  output logic [3:0] channel_request_out, // requests
  output logic hold_grant_out, // buses released
  output logic eop_level_out // end line level
);
  logic [3:0] req_ff, wait_ff, ack_on;
  logic grant_ff, low_ff;
  assign ack_on = ack_high_in ? ack_in : ~ack_in;
  assign channel_request_out = req_ff;
  assign hold_grant_out = grant_ff;
  ////////////////////////////////////////////////////////////
  // request held until its acknowledge shows
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      req_ff <= 4'h0;
    end else begin
      req_ff <= (req_ff | raise_in) & ~ack_on;
    end
  end
  // grant after a chosen delay, withdrawn with the request
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in || !hold_request_in) begin
      wait_ff <= 4'h0;
      grant_ff <= 1'b0;
    end else if (wait_ff == grant_wait_in) begin
      grant_ff <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // outside end pulse while acknowledged, only when asked
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_ff <= 1'b0;
    end else begin
      low_ff <= stop_early_in & (|ack_on) & ~low_ff;
    end
  end
  // open drain with pull-up, high unless pulled
  assign eop_level_out = ~eop_oe_in & ~low_ff;
endmodule // dmabs_partner
`default_nettype wire

// file: bench/dmabs_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); \
  end \
end
// bench for the controller bus signalling
module dmabs_top_bench;
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] ack;
    logic rd, wr, eop, early;
    logic [39:0] fin;
  } dmabs_exp_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] raise = 4'h0, gwait = 4'h0, reload = 4'h0, bload = 4'h0;
  logic [3:0] mclr = 4'h0, rsel = 4'h0, mask_m = 4'hf;
  logic ack_hi = 1'b0, sread = 1'b0, early = 1'b0;
  logic [15:0] baddr = 16'h0000, bcnt = 16'h0000;
  dmabs_pkg::dmabs_xfer_t kind = dmabs_pkg::DMABS_XFER_VERIFY;
  logic [3:0] req, lo_in, lo_out, mid_out, rsel_q, ack, mask, tc;
  logic [15:0] cur_addr, cur_count;
  logic [7:0] db_out;
  logic grant, eop_lvl, eop_oe, eop_o, lo_oe, mid_oe, db_oe, hreq, address_enable;
  logic upper_address_strobe, rd_n, rd_oe, wr_n, wr_oe, s_rd, s_wr, s_eop;
  logic busy = 1'b0, pend = 1'b0;
  int failures = 0, comparisons = 0, idle_n = 0;
  integer seed = 32'h8b24f0bc;
  dmabs_exp_t q[$];
  dmabs_exp_t cur;
  always #5 clk_in = ~clk_in;
  // low address pins: controller in service, host otherwise
  assign lo_in = lo_oe ? lo_out : rsel;
  dmabs_top dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .channel_request_in(req),
    .hold_grant_in(grant), .auto_reload_in(reload),
    .ack_active_high_in(ack_hi), .xfer_kind_in(kind),
    .base_load_in(bload), .base_addr_in(baddr), .base_count_in(bcnt),
    .mask_clear_in(mclr), .status_read_in(sread),
    .end_of_process_n_in(eop_lvl), .end_of_process_n_out(eop_o),
    .end_of_process_n_oe_out(eop_oe), .low_address_nibble_in(lo_in),
    .low_address_nibble_out(lo_out), .low_address_nibble_oe_out(lo_oe),
    .mid_address_nibble_out(mid_out), .mid_address_nibble_oe_out(mid_oe),
    .data_bus_lines_out(db_out), .data_bus_lines_oe_out(db_oe),
    .reg_select_out(rsel_q), .hold_request_out(hreq),
    .channel_acknowledge_out(ack), .address_enable_out(address_enable),
    .upper_address_strobe_out(upper_address_strobe), .memory_read_strobe_n_out(rd_n),
    .memory_read_strobe_n_oe_out(rd_oe), .memory_write_strobe_n_out(wr_n),
    .memory_write_strobe_n_oe_out(wr_oe), .mask_out(mask),
    .terminal_count_out(tc), .cur_addr_out(cur_addr),
    .cur_count_out(cur_count)
  );
  dmabs_partner far_u (
    .clk_in(clk_in), .reset_in(reset_in), .raise_in(raise),
    .grant_wait_in(gwait), .stop_early_in(early), .hold_request_in(hreq),
    .ack_in(ack), .ack_high_in(ack_hi), .eop_oe_in(eop_oe),
    .channel_request_out(req), .hold_grant_out(grant),
    .eop_level_out(eop_lvl)
  );
  ////////////////////////////////////////////////////////////
  // watcher: takes the oldest note when a service shows up
  always @(posedge clk_in) begin
    #2;
    if (busy || pend) begin
      s_rd = s_rd | (rd_oe & ~rd_n);
      s_wr = s_wr | (wr_oe & ~wr_n);
      s_eop = s_eop | (eop_oe & ~eop_o);
    end
    if (pend) begin
      pend = 1'b0;
      `CHK({mask, tc}, cur.fin[39:32])
      `CHK({cur_addr, cur_count}, cur.fin[31:0])
      `CHK(hreq, 1'b0)
      if (!cur.early) begin
        `CHK({s_rd, s_wr}, {cur.rd, cur.wr})
        `CHK(s_eop, cur.eop)
      end
    end
    if (busy && !hreq) begin
      busy = 1'b0;
      pend = 1'b1;
    end
    if (upper_address_strobe && !busy && q.size() > 0) begin
      cur = q.pop_front();
      busy = 1'b1;
      s_rd = 1'b0;
      s_wr = 1'b0;
      s_eop = eop_oe & ~eop_o;
      `CHK({db_out, mid_out, lo_out}, cur.addr)
      `CHK({db_oe, mid_oe, lo_oe, address_enable}, 4'hf)
      `CHK(ack, cur.ack)
    end
    idle_n = (hreq || busy || pend) ? 0 : idle_n + 1;
    if (idle_n > 2) begin
      `CHK({rd_oe,wr_oe,mid_oe,lo_oe,db_oe,address_enable}, 6'h00)
      `CHK(ack, {4{~ack_hi}})
    end
  end
  // step to just after the next rising edge
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  // one single-transfer service on channel n mod 4
  task automatic serve(input int n, input logic rl, input logic ext);
    dmabs_exp_t e;
    logic [3:0] b, m;
    logic [15:0] a, c;
    logic hit;
    int k;
    b = 4'h1 << (n % 4);
    a = 16'($random(seed));
    c = (n % 2 == 1) ? 16'h0000 : 16'h0005 + 16'(n);
    hit = (c == 16'h0000) || ext;
    kind = dmabs_pkg::dmabs_xfer_t'(n % 4);
    reload = rl ? b : 4'h0;
    ack_hi = (n % 3 == 0);
    early = ext;
    gwait = 4'(n);
    baddr = a;
    bcnt = c;
    bload = b;
    sread = 1'b1;
    rsel = 4'($random(seed));
    m = (mask_m & ~b) | ((hit && !rl) ? b : 4'h0);
    e.addr = a;
    e.ack = ack_hi ? b : ~b;
    e.rd = (n % 4 >= 2);
    e.wr = (n % 4 == 1) || (n % 4 == 3);
    e.eop = hit && !ext;
    e.early = ext;
    e.fin = {m, hit ? b : 4'h0, (hit && rl) ? a : a + 16'h1,
             (hit && rl) ? c : c - 16'h1};
    q.push_back(e);
    tick();
    bload = 4'h0;
    sread = 1'b0;
    raise = b;
    tick();
    raise = 4'h0;
    tick();
    `CHK(rsel_q, rsel)
    if ((mask_m & b) != 4'h0) begin
      `CHK(hreq, 1'b0)
      mclr = b;
      tick();
      mclr = 4'h0;
      `CHK(hreq, 1'b1)
    end
    mask_m = m;
    for (k = 0; k < 80 && (busy || pend || idle_n < 3 || q.size() > 0); k++)
      tick();
    if (k == 80) begin
      failures++;
      $display("[FAIL] %0t service never finished", $time);
    end
    $display("test %0d done", n);
  endtask
  // counts, verdict, end of run
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // reset, then each kind, sense, count edge and outside end
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    for (int n = 0; n < 8; n++) serve(n, n >= 4, 1'b0);
    serve(8, 1'b1, 1'b1);
    serve(9, 1'b1, 1'b1);
    print_verdict();
  end
  // ten services of under a hundred cycles each
  initial begin
    #50000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // dmabs_top_bench
`default_nettype wire

// file: src/dmabs_chan_sel.sv
`timescale 1ns/10ps
`default_nettype none
// fixed priority pick of an unmasked request, channel 0 highest
module dmabs_chan_sel (
  input wire logic [3:0] req_in, // raw channel requests
  input wire logic [3:0] mask_in, // mask bits
  output logic any_out, // some request is valid
  output logic [1:0] idx_out // winning channel
);
  logic [3:0] valid;
  assign valid = req_in & ~mask_in;
  assign any_out = |valid;
  // lowest index wins
  always_comb begin
    idx_out = 2'h0;
    for (int i = dmabs_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (valid[i]) begin
        idx_out = 2'(i);
      end
    end
  end
endmodule // dmabs_chan_sel
`default_nettype wire

// file: src/dmabs_pkg.sv
package dmabs_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned CNT_W = 16;
  // address field positions
  localparam int unsigned LOW_LSB = 0;
  localparam int unsigned MID_LSB = 4;
  localparam int unsigned UPP_LSB = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned BYTE_W = 8;
  // reset values
  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [3:0] ZERO4 = 4'h0;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] CNT_ROLL = 16'hffff;
  // transfer kinds
  typedef enum logic [1:0] {
    DMABS_XFER_VERIFY,
    DMABS_XFER_IO_TO_MEM,
    DMABS_XFER_MEM_TO_IO,
    DMABS_XFER_MEM_TO_MEM
  } dmabs_xfer_t;
endpackage : dmabs_pkg

// file: src/dmabs_top.sv
`timescale 1ns/10ps
`default_nettype none
module dmabs_top (
  input wire logic clk_in, // 100 mhz clock
  input wire logic reset_in, // async active high
  input wire logic [3:0] channel_request_in, // peripheral requests
  input wire logic hold_grant_in, // processor released buses
  input wire logic [3:0] auto_reload_in, // per-channel reload enable
  input wire logic ack_active_high_in, // acknowledge sense
  input wire dmabs_pkg::dmabs_xfer_t xfer_kind_in, // transfer kind
  input wire logic [3:0] base_load_in, // load base registers
  input wire logic [15:0] base_addr_in, // base address to load
  input wire logic [15:0] base_count_in, // base count to load
  input wire logic [3:0] mask_clear_in, // clear mask bits
  input wire logic status_read_in, // clears terminal-count bits
  input wire logic end_of_process_n_in, // sensed pin level
  output logic end_of_process_n_out, // driven level, low only
  output logic end_of_process_n_oe_out, // drive enable
  input wire logic [3:0] low_address_nibble_in, // register select
  output logic [3:0] low_address_nibble_out, // address bits 3:0
  output logic low_address_nibble_oe_out, // drive enable
  output logic [3:0] mid_address_nibble_out, // address bits 7:4
  output logic mid_address_nibble_oe_out, // drive enable
  output logic [7:0] data_bus_lines_out, // upper address byte
  output logic data_bus_lines_oe_out, // drive enable
  output logic [3:0] reg_select_out, // sampled idle register select
  output logic hold_request_out, // to processor
  output logic [3:0] channel_acknowledge_out, // to peripherals
  output logic address_enable_out, // gates upper latch
  output logic upper_address_strobe_out, // latches upper byte
  output logic memory_read_strobe_n_out, // active low
  output logic memory_read_strobe_n_oe_out, // drive enable
  output logic memory_write_strobe_n_out, // active low
  output logic memory_write_strobe_n_oe_out, // drive enable
  output logic [3:0] mask_out, // mask bits
  output logic [3:0] terminal_count_out, // status bits
  output logic [15:0] cur_addr_out, // serviced channel address
  output logic [15:0] cur_count_out // serviced channel count
);
  typedef enum logic [2:0] {
    DMABS_IDLE, DMABS_WAIT, DMABS_ADR, DMABS_RD, DMABS_WR, DMABS_DONE
  } dmabs_state_t;

  dmabs_state_t state_ff, nxt_state;
  logic [1:0] chan_ff;
  logic [3:0] mask_ff, tc_ff, req_clr_ff;
  logic [15:0] base_addr_ff [4];
  logic [15:0] base_cnt_ff [4];
  logic [15:0] cur_addr_ff [4];
  logic [15:0] cur_cnt_ff [4];
  logic eop_drive_ff;
  logic [3:0] sel_ff;
  logic any_req;
  logic [1:0] win_idx;
  logic in_service, xfer_end, tc_hit, ext_eop, eop_evt;
  logic [3:0] req_eff;

  ////////////////////////////////////////////////////////////////////////
  // channel choice; a request ended by end of process stays cleared until it drops
  assign req_eff = channel_request_in & ~req_clr_ff;
  dmabs_chan_sel u_sel (
    .req_in(req_eff),
    .mask_in(mask_ff),
    .any_out(any_req),
    .idx_out(win_idx)
  );

  // service phase decode
  assign in_service = (state_ff == DMABS_ADR) || (state_ff == DMABS_RD) ||
                      (state_ff == DMABS_WR);
  assign xfer_end = (state_ff == DMABS_WR) ||
    ((state_ff == DMABS_RD) &&
     (xfer_kind_in != dmabs_pkg::DMABS_XFER_MEM_TO_MEM));
  assign tc_hit = xfer_end && (cur_cnt_ff[chan_ff] == dmabs_pkg::ZERO16);
  assign ext_eop = in_service && !end_of_process_n_in;
  assign eop_evt = tc_hit || ext_eop;

  ////////////////////////////////////////////////////////////////////////
  // service sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DMABS_IDLE: if (any_req) nxt_state = DMABS_WAIT;
      DMABS_WAIT: begin
        if (!any_req) nxt_state = DMABS_IDLE;
        else if (hold_grant_in) nxt_state = DMABS_ADR;
      end
      DMABS_ADR: nxt_state = eop_evt ? DMABS_DONE : DMABS_RD;
      DMABS_RD: begin
        if (eop_evt) nxt_state = DMABS_DONE;
        else if (xfer_kind_in == dmabs_pkg::DMABS_XFER_MEM_TO_MEM)
          nxt_state = DMABS_WR;
        else nxt_state = DMABS_DONE;
      end
      DMABS_WR: nxt_state = DMABS_DONE;
      DMABS_DONE: nxt_state = DMABS_IDLE;
      default: nxt_state = DMABS_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) state_ff <= DMABS_IDLE;
    else state_ff <= nxt_state;
  end
  // latch the winning channel when the grant arrives
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) chan_ff <= 2'h0;
    else if (state_ff == DMABS_WAIT && hold_grant_in) chan_ff <= win_idx;
  end
  // request clear on end of process, released when request drops
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      req_clr_ff <= dmabs_pkg::ZERO4;
    end else begin
      for (int i = 0; i < dmabs_pkg::NUM_CH; i++) begin
        if (eop_evt && chan_ff == 2'(i)) req_clr_ff[i] <= 1'b1;
        else if (!channel_request_in[i]) req_clr_ff[i] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // per-channel address and count storage
  for (genvar g = 0; g < dmabs_pkg::NUM_CH; g++) begin : g_ch
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        base_addr_ff[g] <= dmabs_pkg::ZERO16;
        base_cnt_ff[g] <= dmabs_pkg::ZERO16;
        cur_addr_ff[g] <= dmabs_pkg::ZERO16;
        cur_cnt_ff[g] <= dmabs_pkg::ZERO16;
      end else if (base_load_in[g]) begin
        base_addr_ff[g] <= base_addr_in;
        base_cnt_ff[g] <= base_count_in;
        cur_addr_ff[g] <= base_addr_in;
        cur_cnt_ff[g] <= base_count_in;
      end else if (eop_evt && chan_ff == 2'(g) && auto_reload_in[g]) begin
        cur_addr_ff[g] <= base_addr_ff[g];
        cur_cnt_ff[g] <= base_cnt_ff[g];
      end else if (xfer_end && chan_ff == 2'(g)) begin
        cur_addr_ff[g] <= cur_addr_ff[g] + dmabs_pkg::ONE16;
        cur_cnt_ff[g] <= cur_cnt_ff[g] - dmabs_pkg::ONE16;
      end
    end
  end
  // mask and terminal-count status; hardware set wins over clear
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mask_ff <= dmabs_pkg::MASK_RST;
      tc_ff <= dmabs_pkg::ZERO4;
    end else begin
      for (int i = 0; i < dmabs_pkg::NUM_CH; i++) begin
        if (eop_evt && chan_ff == 2'(i)) begin
          tc_ff[i] <= 1'b1;
          if (!auto_reload_in[i]) mask_ff[i] <= 1'b1;
        end else begin
          if (status_read_in) tc_ff[i] <= 1'b0;
          if (mask_clear_in[i]) mask_ff[i] <= 1'b0;
        end
      end
    end
  end
  // one-cycle low drive of end of process after terminal count
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) eop_drive_ff <= 1'b0;
    else eop_drive_ff <= tc_hit;
  end
  // register select sampled while idle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) sel_ff <= dmabs_pkg::ZERO4;
    else if (state_ff == DMABS_IDLE) sel_ff <= low_address_nibble_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive
  assign end_of_process_n_out = 1'b0;
  assign end_of_process_n_oe_out = eop_drive_ff;
  assign reg_select_out = sel_ff;
  assign low_address_nibble_out =
    cur_addr_ff[chan_ff][dmabs_pkg::LOW_LSB +: dmabs_pkg::NIB_W];
  assign low_address_nibble_oe_out = in_service;
  assign mid_address_nibble_out =
    cur_addr_ff[chan_ff][dmabs_pkg::MID_LSB +: dmabs_pkg::NIB_W];
  assign mid_address_nibble_oe_out = in_service;
  assign data_bus_lines_out =
    cur_addr_ff[chan_ff][dmabs_pkg::UPP_LSB +: dmabs_pkg::BYTE_W];
  assign data_bus_lines_oe_out = (state_ff == DMABS_ADR);
  assign hold_request_out = any_req || in_service;
  assign address_enable_out = in_service;
  assign upper_address_strobe_out = (state_ff == DMABS_ADR);
  // acknowledges, inactive level follows programmed sense
  always_comb begin
    for (int i = 0; i < dmabs_pkg::NUM_CH; i++) begin
      channel_acknowledge_out[i] = ack_active_high_in ~^
        (in_service && chan_ff == 2'(i));
    end
  end
  assign memory_read_strobe_n_out = !((state_ff == DMABS_RD) &&
    (xfer_kind_in == dmabs_pkg::DMABS_XFER_MEM_TO_IO ||
     xfer_kind_in == dmabs_pkg::DMABS_XFER_MEM_TO_MEM));
  assign memory_read_strobe_n_oe_out = in_service;
  assign memory_write_strobe_n_out = !(
    ((state_ff == DMABS_RD) &&
     (xfer_kind_in == dmabs_pkg::DMABS_XFER_IO_TO_MEM)) ||
    (state_ff == DMABS_WR));
  assign memory_write_strobe_n_oe_out = in_service;
  assign mask_out = mask_ff;
  assign terminal_count_out = tc_ff;
  assign cur_addr_out = cur_addr_ff[chan_ff];
  assign cur_count_out = cur_cnt_ff[chan_ff];

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_grant;
    state_ff == DMABS_WAIT && any_req && hold_grant_in;
  endsequence
  sequence s_strobe;
    upper_address_strobe_out && address_enable_out;
  endsequence
  property p_eop_pulse;
    @(posedge clk_in) disable iff (reset_in)
    tc_hit |=> end_of_process_n_oe_out ##1 !end_of_process_n_oe_out;
  endproperty
  a_eop_pulse: assert property (p_eop_pulse)
    else $error("terminal count gave no one-cycle end of process");
  property p_ext_end;
    @(posedge clk_in) disable iff (reset_in)
    ext_eop |=> state_ff == DMABS_DONE ##1 state_ff == DMABS_IDLE;
  endproperty
  a_ext_end: assert property (p_ext_end)
    else $error("outside end of process did not end service");
  property p_tc_set;
    @(posedge clk_in) disable iff (reset_in)
    eop_evt |=> terminal_count_out[$past(chan_ff)];
  endproperty
  a_tc_set: assert property (p_tc_set)
    else $error("terminal-count bit not set");
  property p_mask_keep;
    @(posedge clk_in) disable iff (reset_in)
    eop_evt && auto_reload_in[chan_ff] && !mask_clear_in[chan_ff]
      |=> mask_ff[$past(chan_ff)] == $past(mask_ff[chan_ff]);
  endproperty
  a_mask_keep: assert property (p_mask_keep)
    else $error("reload channel mask changed");
  property p_reload;
    @(posedge clk_in) disable iff (reset_in)
    eop_evt && auto_reload_in[chan_ff] && !base_load_in[chan_ff]
      |=> cur_count_out == $past(base_cnt_ff[chan_ff]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("current count not reloaded");
  property p_hold;
    @(posedge clk_in) disable iff (reset_in)
    (|(channel_request_in & ~mask_ff & ~req_clr_ff)) |-> hold_request_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold request missing");
  // an outside end in the strobe cycle ends service at once
  property p_service;
    @(posedge clk_in) disable iff (reset_in)
    s_grant |=> s_strobe ##1 (!upper_address_strobe_out &&
      address_enable_out == !$past(ext_eop));
  endproperty
  a_service: assert property (p_service)
    else $error("service start strobe sequence wrong");
  property p_idle_release;
    @(posedge clk_in) disable iff (reset_in)
    !in_service |-> !mid_address_nibble_oe_out && !memory_read_strobe_n_oe_out
      && !memory_write_strobe_n_oe_out && !low_address_nibble_oe_out;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("pins driven outside service");
  property p_m2m;
    @(posedge clk_in) disable iff (reset_in)
    state_ff == DMABS_RD && !eop_evt &&
      xfer_kind_in == dmabs_pkg::DMABS_XFER_MEM_TO_MEM
      |-> !memory_read_strobe_n_out ##1 !memory_write_strobe_n_out;
  endproperty
  a_m2m: assert property (p_m2m)
    else $error("memory to memory strobes wrong");
endmodule // dmabs_top
`default_nettype wire
